// [include/cmc_pkg.sv]
// constants, register map and state type for the CAN master mode control block
// assumes a 40 MHz peripheral clock and a fixed nominal bit time on the bus
package cmc_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int BIT_TIME_NS = 1000;
   // longest whole number of clocks inside one bit time
   localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
   localparam int IDLE_RUN_BITS = 11;
   localparam int BUSOFF_RUNS = 128;

   localparam logic [11:0] OFS_MASTER_CONTROL = 12'h000;
   localparam logic [11:0] OFS_MASTER_STATUS = 12'h004;
   localparam logic [11:0] OFS_IRQ_ENABLE = 12'h014;

   localparam logic [31:0] MCTRL_RESET = 32'h0001_0002;
   localparam logic [31:0] MCTRL_RW_MASK = 32'h0001_00ff;

   localparam int BIT_DEBUG_FREEZE = 16;
   localparam int BIT_SOFT_RESET = 15;
   localparam int BIT_TIME_TRIGGERED = 7;
   localparam int BIT_AUTO_BUSOFF = 6;
   localparam int BIT_AUTO_WAKEUP = 5;
   localparam int BIT_NO_RETRANSMIT = 4;
   localparam int BIT_RX_FIFO_LOCK = 3;
   localparam int BIT_TX_ORDER = 2;
   localparam int BIT_SLEEP_REQUEST = 1;
   localparam int BIT_INIT_REQUEST = 0;

   localparam int BIT_RX_LEVEL = 11;
   localparam int BIT_WAKEUP_FLAG = 3;
   localparam int BIT_SLEEP_ACK = 1;
   localparam int BIT_INIT_ACK = 0;
   localparam int BIT_WAKEUP_IE = 3;

   typedef enum logic [1:0] {
      ST_SLEEP = 2'b00,
      ST_INIT = 2'b01,
      ST_SYNC = 2'b10,
      ST_NORMAL = 2'b11
   } cmc_state_t;
endpackage

// [rtl/cmc_sync2.sv]
// two flip-flop synchroniser for pin-level inputs
// assumes inputs are static levels; reset value chosen by parameter
`timescale 1ns/100ps
`default_nettype none
module cmc_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   initial begin
      if (W < 1) $error("cmc_sync2: width must be positive");
   end

   always_comb begin
      next_meta = d_i;
      next_q = meta;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         meta <= RESET_VAL;
         q_o <= RESET_VAL;
      end else begin
         meta <= next_meta;
         q_o <= next_q;
      end
   end
endmodule
`default_nettype wire

// [rtl/cmc_idle_detect.sv]
// finds runs of consecutive recessive bits on the synchronised receive line
// assumes rx_i is already synchronised; the bit grid is free running
`timescale 1ns/100ps
`default_nettype none
module cmc_idle_detect
   import cmc_pkg::*;
#(
   parameter int BIT_CLKS = BIT_CYCLES,
   parameter int RUN_BITS = IDLE_RUN_BITS
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic rx_i,
   input wire logic restart_i,
   output logic run_done_o
);
   logic [15:0] div;
   logic [7:0] run;
   logic [15:0] next_div;
   logic [7:0] next_run;
   logic next_done;
   logic tick;

   initial begin
      if (BIT_CLKS < 2 || BIT_CLKS > 65535) $error("cmc_idle_detect: bad bit length");
      if (RUN_BITS < 1 || RUN_BITS > 255) $error("cmc_idle_detect: bad run length");
   end

   always_comb begin
      tick = (div == 16'(BIT_CLKS - 1));
      next_div = tick ? 16'h0000 : div + 16'h0001;
      next_run = run;
      next_done = 1'b0;
      // a dominant level anywhere in the run starts the count over
      if (restart_i || !rx_i) begin
         next_run = 8'h00;
      end else if (tick) begin
         if (run == 8'(RUN_BITS - 1)) begin
            next_run = 8'h00;
            next_done = 1'b1;
         end else begin
            next_run = run + 8'h01;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         div <= 16'h0000;
         run <= 8'h00;
         run_done_o <= 1'b0;
      end else begin
         div <= next_div;
         run <= next_run;
         run_done_o <= next_done;
      end
   end
endmodule
`default_nettype wire

// [rtl/cmc_master_ctrl.sv]
// CAN master mode control: control/status registers on APB, mode sequencing
// assumes the protocol engine shares clock_i; rx pin and debug halt are asynchronous
`timescale 1ns/100ps
`default_nettype none
module cmc_master_ctrl
   import cmc_pkg::*;
#(
   parameter int BIT_CLKS = BIT_CYCLES
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic rx_pin_i,
   input wire logic debug_halt_i,
   input wire logic bus_busy_i,
   input wire logic bus_off_i,
   input wire logic tx_end_i,
   input wire logic tx_fail_i,
   input wire logic rx_msg_i,
   input wire logic rx_fifo_full_i,
   output cmc_pkg::cmc_state_t mode_o,
   output logic init_ack_o,
   output logic sleep_ack_o,
   output logic freeze_o,
   output logic time_triggered_mode_o,
   output logic tx_order_select_o,
   output logic fifo_clear_o,
   output logic busoff_exit_o,
   output logic retransmit_o,
   output logic rx_overwrite_o,
   output logic rx_discard_o,
   output logic state_change_irq_o
);
   import cmc_pkg::*;

   logic rx_s, halt_s, sync_done, bo_done;

   cmc_sync2 #(.W(2), .RESET_VAL(2'b10)) u_sync (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .d_i({rx_pin_i, debug_halt_i}),
      .q_o({rx_s, halt_s})
   );

   // control and mode state
   logic [31:0] ctrl;
   logic [31:0] next_ctrl;
   cmc_state_t state;
   cmc_state_t next_state;
   logic soft_master_reset, init_ack, sleep_ack, wake_flag, wake_ie, rx_prev;
   logic next_soft_master_reset, next_init_ack, next_sleep_ack, next_wake_flag, next_wake_ie;
   logic wr, sof, go_wake;

   always_comb begin
      next_ctrl = ctrl;
      next_soft_master_reset = 1'b0;
      next_state = state;
      next_init_ack = init_ack;
      next_sleep_ack = sleep_ack;
      next_wake_flag = wake_flag;
      next_wake_ie = wake_ie;
      go_wake = 1'b0;
      wr = psel_i && penable_i && pwrite_i && pready_o;
      sof = rx_prev && !rx_s;
      if (soft_master_reset) begin
         next_ctrl = MCTRL_RESET;
         next_state = ST_SLEEP;
         next_init_ack = 1'b0;
         next_sleep_ack = 1'b1;
      end else begin
         if (wr && paddr_i == OFS_MASTER_CONTROL) begin
            next_ctrl = pwdata_i & MCTRL_RW_MASK;
            next_soft_master_reset = pwdata_i[BIT_SOFT_RESET];
         end
         if (wr && paddr_i == OFS_IRQ_ENABLE) begin
            next_wake_ie = pwdata_i[BIT_WAKEUP_IE];
         end
         if (wr && paddr_i == OFS_MASTER_STATUS && pwdata_i[BIT_WAKEUP_FLAG]) begin
            next_wake_flag = 1'b0;
         end
         case (state)
            ST_SLEEP: begin
               if (ctrl[BIT_SLEEP_REQUEST] && ctrl[BIT_AUTO_WAKEUP] && sof) begin
                  next_ctrl[BIT_SLEEP_REQUEST] = 1'b0;
                  next_sleep_ack = 1'b0;
                  go_wake = 1'b1;
               end else if (!ctrl[BIT_SLEEP_REQUEST]) begin
                  go_wake = 1'b1;
               end
               if (go_wake && ctrl[BIT_INIT_REQUEST]) begin
                  next_state = ST_INIT;
                  next_init_ack = 1'b1;
                  next_sleep_ack = 1'b0;
               end else if (go_wake) begin
                  next_state = ST_SYNC;
               end
            end
            ST_INIT: begin
               if (!ctrl[BIT_INIT_REQUEST] && ctrl[BIT_SLEEP_REQUEST]) begin
                  next_state = ST_SLEEP;
                  next_init_ack = 1'b0;
                  next_sleep_ack = 1'b1;
               end else if (!ctrl[BIT_INIT_REQUEST]) begin
                  next_state = ST_SYNC;
               end
            end
            ST_SYNC: begin
               if (ctrl[BIT_INIT_REQUEST]) begin
                  next_state = ST_INIT;
                  next_init_ack = 1'b1;
                  next_sleep_ack = 1'b0;
               end else if (ctrl[BIT_SLEEP_REQUEST]) begin
                  next_state = ST_SLEEP;
                  next_init_ack = 1'b0;
                  next_sleep_ack = 1'b1;
               end else if (sync_done) begin
                  next_state = ST_NORMAL;
                  next_init_ack = 1'b0;
                  next_sleep_ack = 1'b0;
               end
            end
            default: begin
               // requests wait for the frame on the bus to finish
               if (!bus_busy_i && ctrl[BIT_INIT_REQUEST]) begin
                  next_state = ST_INIT;
                  next_init_ack = 1'b1;
               end else if (!bus_busy_i && ctrl[BIT_SLEEP_REQUEST]) begin
                  next_state = ST_SLEEP;
                  next_sleep_ack = 1'b1;
               end
            end
         endcase
         // set placed after the clear so a coincident event is kept
         if (state == ST_SLEEP && sof) begin
            next_wake_flag = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         ctrl <= MCTRL_RESET;
         soft_master_reset <= 1'b0;
         state <= ST_SLEEP;
         init_ack <= 1'b0;
         sleep_ack <= 1'b1;
         wake_flag <= 1'b0;
         wake_ie <= 1'b0;
         rx_prev <= 1'b1;
      end else begin
         ctrl <= next_ctrl;
         soft_master_reset <= next_soft_master_reset;
         state <= next_state;
         init_ack <= next_init_ack;
         sleep_ack <= next_sleep_ack;
         wake_flag <= next_wake_flag;
         wake_ie <= next_wake_ie;
         rx_prev <= rx_s;
      end
   end

   cmc_idle_detect #(.BIT_CLKS(BIT_CLKS), .RUN_BITS(IDLE_RUN_BITS)) u_sync_idle (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .rx_i(rx_s),
      .restart_i(state != ST_SYNC),
      .run_done_o(sync_done)
   );

   // bus-off recovery
   logic seen_init;
   logic [6:0] bo_count;
   logic next_seen_init;
   logic [6:0] next_bo_count;
   logic next_bo_exit;
   logic counting;

   always_comb begin
      counting = bus_off_i && (ctrl[BIT_AUTO_BUSOFF] || (seen_init && !ctrl[BIT_INIT_REQUEST]));
      next_seen_init = bus_off_i && (seen_init || ctrl[BIT_INIT_REQUEST]);
      next_bo_count = bo_count;
      next_bo_exit = 1'b0;
      if (!counting || soft_master_reset) begin
         next_bo_count = 7'h00;
      end else if (bo_done) begin
         next_bo_count = bo_count + 7'h01;
         if (bo_count == 7'(BUSOFF_RUNS - 1)) begin
            next_bo_exit = 1'b1;
            next_seen_init = 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         seen_init <= 1'b0;
         bo_count <= 7'h00;
         busoff_exit_o <= 1'b0;
      end else begin
         seen_init <= next_seen_init;
         bo_count <= next_bo_count;
         busoff_exit_o <= next_bo_exit;
      end
   end

   cmc_idle_detect #(.BIT_CLKS(BIT_CLKS), .RUN_BITS(IDLE_RUN_BITS)) u_bo_idle (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .rx_i(rx_s),
      .restart_i(!counting),
      .run_done_o(bo_done)
   );

   // APB answer and engine-facing outputs
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic setup;

   always_comb begin
      setup = psel_i && !penable_i;
      next_pready = setup;
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      if (setup && paddr_i == OFS_MASTER_CONTROL) begin
         next_prdata = ctrl;
      end else if (setup && paddr_i == OFS_MASTER_STATUS) begin
         next_prdata[BIT_RX_LEVEL] = rx_s;
         next_prdata[BIT_WAKEUP_FLAG] = wake_flag;
         next_prdata[BIT_SLEEP_ACK] = sleep_ack;
         next_prdata[BIT_INIT_ACK] = init_ack;
      end else if (setup && paddr_i == OFS_IRQ_ENABLE) begin
         next_prdata[BIT_WAKEUP_IE] = wake_ie;
      end else if (setup) begin
         next_pslverr = 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         freeze_o <= 1'b0;
         fifo_clear_o <= 1'b0;
         retransmit_o <= 1'b0;
         rx_overwrite_o <= 1'b0;
         rx_discard_o <= 1'b0;
         state_change_irq_o <= 1'b0;
      end else begin
         prdata_o <= next_prdata;
         pready_o <= next_pready;
         pslverr_o <= next_pslverr;
         freeze_o <= ctrl[BIT_DEBUG_FREEZE] && halt_s;
         fifo_clear_o <= soft_master_reset;
         retransmit_o <= tx_end_i && tx_fail_i && !ctrl[BIT_NO_RETRANSMIT];
         rx_overwrite_o <= rx_msg_i && rx_fifo_full_i && !ctrl[BIT_RX_FIFO_LOCK];
         rx_discard_o <= rx_msg_i && rx_fifo_full_i && ctrl[BIT_RX_FIFO_LOCK];
         state_change_irq_o <= next_wake_flag && next_wake_ie;
      end
   end

   assign mode_o = state;
   assign init_ack_o = init_ack;
   assign sleep_ack_o = sleep_ack;
   assign time_triggered_mode_o = ctrl[BIT_TIME_TRIGGERED];
   assign tx_order_select_o = ctrl[BIT_TX_ORDER];

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   a_freeze_follows_halt: assert property (ctrl[BIT_DEBUG_FREEZE] && halt_s |=> freeze_o)
      else $error("freeze missing under debug halt");
   a_soft_master_reset_self_clear: assert property (soft_master_reset |=> !soft_master_reset && ctrl == MCTRL_RESET
      && state == ST_SLEEP && fifo_clear_o)
      else $error("master reset did not complete");
   a_busoff_gated: assert property (bus_off_i && !ctrl[BIT_AUTO_BUSOFF] && !seen_init |=> !busoff_exit_o)
      else $error("bus-off left without init request");
   a_busoff_count: assert property (busoff_exit_o |-> $past(bo_count) == 7'h7f && $past(bo_done))
      else $error("bus-off left before 128 idle runs");
   a_sleep_hold: assert property (state == ST_SLEEP && ctrl[BIT_SLEEP_REQUEST] && !ctrl[BIT_AUTO_WAKEUP] && !soft_master_reset && !wr |=> state == ST_SLEEP)
      else $error("left sleep without software");
   a_auto_wake: assert property (state == ST_SLEEP && ctrl[BIT_SLEEP_REQUEST] && ctrl[BIT_AUTO_WAKEUP] && sof && !soft_master_reset |=> !ctrl[BIT_SLEEP_REQUEST] && !sleep_ack && wake_flag)
      else $error("auto wake-up incomplete");
   a_retry_only_enabled: assert property (retransmit_o |-> !$past(ctrl[BIT_NO_RETRANSMIT]))
      else $error("retry with retransmission off");
   a_retry_issued: assert property (tx_end_i && tx_fail_i && !ctrl[BIT_NO_RETRANSMIT] |=> retransmit_o)
      else $error("failed message not retried");
   a_fifo_lock: assert property (rx_msg_i && rx_fifo_full_i |=> rx_discard_o == $past(ctrl[BIT_RX_FIFO_LOCK]) && rx_overwrite_o != rx_discard_o)
      else $error("overflow handling wrong");
   a_sleep_waits: assert property (state == ST_NORMAL && bus_busy_i && !soft_master_reset |=> state == ST_NORMAL)
      else $error("mode left during traffic");
   a_sleep_entry: assert property (state == ST_NORMAL && !bus_busy_i && ctrl[BIT_SLEEP_REQUEST] && !ctrl[BIT_INIT_REQUEST] && !soft_master_reset |=> state == ST_SLEEP && sleep_ack)
      else $error("sleep not entered");
   a_init_entry: assert property (state == ST_NORMAL && !bus_busy_i && ctrl[BIT_INIT_REQUEST] && !soft_master_reset |=> state == ST_INIT && init_ack)
      else $error("init not entered");
   a_sync_exit: assert property (state == ST_NORMAL && $past(state) != ST_NORMAL |-> $past(sync_done) && !init_ack && !sleep_ack)
      else $error("normal entered without bus idle");
   a_reset_value: assert property ($past(rst_b_i) == 1'b0 |-> ctrl == MCTRL_RESET && sleep_ack)
      else $error("control reset value wrong");
   a_reserved_zero: assert property ((ctrl & ~MCTRL_RW_MASK) == 32'h0000_0000)
      else $error("reserved control bits set");

   c_auto_wake: cover property (state == ST_SLEEP && sof && ctrl[BIT_AUTO_WAKEUP]);
   c_normal_entry: cover property (state == ST_SYNC ##1 state == ST_NORMAL);
   c_busoff_exit: cover property (busoff_exit_o);
   c_soft_reset: cover property (soft_master_reset);
endmodule
`default_nettype wire

// [verif/cmc_bus_model.sv]
// model of the CAN bus as seen from the receive pin, plus a frame-busy level
// assumes the bench asks for one frame with a single-cycle pulse on send_i
`timescale 1ns/100ps
`default_nettype none
module cmc_bus_model #(
   parameter int BIT_CLKS = 4,
   parameter int FRAME_BITS = 20
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic send_i,
   output logic rx_pin_o,
   output logic busy_o
);
   int cnt;
   always_ff @(posedge clock_i) begin
      if (!rst_b_i || cnt == 0) begin
         cnt <= (rst_b_i && send_i) ? FRAME_BITS * BIT_CLKS : 0;
      end else begin
         cnt <= cnt - 1;
      end
   end
   // recessive when idle; inside a frame bits alternate so no idle run forms
   assign rx_pin_o = (cnt == 0) ? 1'b1 :
                     (cnt > (FRAME_BITS - 1) * BIT_CLKS) ? 1'b0 :
                     ((cnt / BIT_CLKS) % 2) == 1;
   assign busy_o = (cnt != 0);
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the CAN master mode control block
// assumes the APB slave answers by pready and a bit time of four clocks
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import cmc_pkg::*;
   localparam int BC = 4;
   localparam int LO = (BUSOFF_RUNS * IDLE_RUN_BITS - 2) * BC;
   localparam int HI = (BUSOFF_RUNS * IDLE_RUN_BITS + 2) * BC + 8;
   // o: time trig, order, retransmit, overwrite, discard
   typedef struct {logic [31:0] w; logic [31:0] r; logic [4:0] o;} cmc_row_t;
   cmc_row_t rows[4] = '{
      '{32'h0000_0080, 32'h0000_0080, 5'b10110},
      '{32'h0001_0014, 32'h0001_0014, 5'b01010},
      '{32'h0000_0008, 32'h0000_0008, 5'b00101},
      '{32'hfffe_7f5c, 32'h0000_005c, 5'b01001}};
   logic clk, rst_b, psel, penable, pwrite, halt, boff, tx_end, tx_fail, rx_msg, rx_full, send;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, rx_pin, busy, init_ack, sleep_ack, freeze, ttm, order;
   logic fclr, bexit, retx, ovw, disc, irq;
   cmc_state_t mode;
   int n_errors = 0;
   int checks = 0;
   int n_clr = 0;
   int n, c0;

   cmc_master_ctrl #(.BIT_CLKS(BC)) cmc_master_ctrl_i (.clock_i(clk), .rst_b_i(rst_b),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .rx_pin_i(rx_pin), .debug_halt_i(halt), .bus_busy_i(busy), .bus_off_i(boff),
      .tx_end_i(tx_end), .tx_fail_i(tx_fail), .rx_msg_i(rx_msg), .rx_fifo_full_i(rx_full),
      .mode_o(mode), .init_ack_o(init_ack), .sleep_ack_o(sleep_ack), .freeze_o(freeze),
      .time_triggered_mode_o(ttm), .tx_order_select_o(order), .fifo_clear_o(fclr),
      .busoff_exit_o(bexit), .retransmit_o(retx), .rx_overwrite_o(ovw),
      .rx_discard_o(disc), .state_change_irq_o(irq));
   cmc_bus_model #(.BIT_CLKS(BC)) cmc_bus_model_i (.clock_i(clk), .rst_b_i(rst_b),
      .send_i(send), .rx_pin_o(rx_pin), .busy_o(busy));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) if (fclr === 1'b1) n_clr <= n_clr + 1;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      if (pready !== 1'b1) n_errors++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic xerr);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk("prdata", q, exp);
      chk("pslverr", e, xerr);
   endtask
   task automatic wait_mode(input cmc_state_t m, input int lim);
      int k;
      k = 0;
      while (mode !== m && k < lim) begin
         @(posedge clk);
         k++;
      end
      chk("mode", mode, m);
   endtask
   task automatic busoff_wait(output int k);
      k = 0;
      while (bexit !== 1'b1 && k < 7000) begin
         @(posedge clk);
         k++;
      end
   endtask
   task automatic frame();
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
   endtask
   task automatic tally_and_finish();
      if (n_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // hang guard, well above the longest bus-off wait
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      tally_and_finish();
   end

   initial begin
      {rst_b, psel, penable, pwrite, halt, boff, tx_end, tx_fail, rx_msg, rx_full, send} = '0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd_chk(OFS_MASTER_CONTROL, MCTRL_RESET, 1'b0);
      chk("mode", mode, ST_SLEEP);
      chk("sleep_ack", sleep_ack, 1'b1);
      rd_chk(OFS_MASTER_STATUS, 32'h0000_0802, 1'b0);
      rd_chk(12'h008, 32'h0000_0000, 1'b1);
      frame();
      repeat (100) @(posedge clk);
      chk("mode", mode, ST_SLEEP);
      wr(OFS_MASTER_CONTROL, 32'h0000_0000);
      repeat (20) @(posedge clk);
      chk("mode", mode, ST_SYNC);
      chk("sleep_ack", sleep_ack, 1'b1);
      wait_mode(ST_NORMAL, 300);
      chk("sleep_ack", sleep_ack, 1'b0);
      chk("init_ack", init_ack, 1'b0);
      foreach (rows[i]) begin
         wr(OFS_MASTER_CONTROL, rows[i].w);
         rd_chk(OFS_MASTER_CONTROL, rows[i].r, 1'b0);
         chk("time_trig", ttm, rows[i].o[4]);
         chk("tx_order", order, rows[i].o[3]);
         {tx_end, tx_fail, rx_msg, rx_full} <= 4'hf;
         @(posedge clk);
         {tx_end, rx_msg} <= 2'b00;
         #1;
         chk("retransmit", retx, rows[i].o[2]);
         chk("overwrite", ovw, rows[i].o[1]);
         chk("discard", disc, rows[i].o[0]);
         @(posedge clk);
      end
      halt <= 1'b1;
      wr(OFS_MASTER_CONTROL, 32'h0001_0000);
      repeat (4) @(posedge clk);
      chk("freeze", freeze, 1'b1);
      wr(OFS_MASTER_CONTROL, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk("freeze", freeze, 1'b0);
      halt <= 1'b0;
      frame();
      repeat (2) @(posedge clk);
      wr(OFS_MASTER_CONTROL, 32'h0000_0001);
      chk("mode", mode, ST_NORMAL);
      chk("init_ack", init_ack, 1'b0);
      wait_mode(ST_INIT, 200);
      chk("busy", busy, 1'b0);
      chk("init_ack", init_ack, 1'b1);
      wr(OFS_MASTER_CONTROL, 32'h0000_0000);
      wait_mode(ST_NORMAL, 300);
      chk("init_ack", init_ack, 1'b0);
      wr(OFS_MASTER_CONTROL, 32'h0000_0002);
      wait_mode(ST_SLEEP, 10);
      chk("sleep_ack", sleep_ack, 1'b1);
      wr(OFS_MASTER_STATUS, 32'h0000_0008);
      wr(OFS_IRQ_ENABLE, 32'h0000_0008);
      wr(OFS_MASTER_CONTROL, 32'h0000_0022);
      chk("irq", irq, 1'b0);
      frame();
      wait_mode(ST_SYNC, 20);
      chk("sleep_ack", sleep_ack, 1'b0);
      rd_chk(OFS_MASTER_CONTROL, 32'h0000_0020, 1'b0);
      chk("irq", irq, 1'b1);
      wr(OFS_MASTER_STATUS, 32'h0000_0008);
      repeat (2) @(posedge clk);
      chk("irq", irq, 1'b0);
      wait_mode(ST_NORMAL, 400);
      c0 = n_clr;
      wr(OFS_MASTER_CONTROL, 32'h0000_8080);
      repeat (3) @(posedge clk);
      chk("mode", mode, ST_SLEEP);
      rd_chk(OFS_MASTER_CONTROL, MCTRL_RESET, 1'b0);
      chk("fifo_clear", n_clr - c0, 1);
      wr(OFS_MASTER_CONTROL, 32'h0000_0040);
      wait_mode(ST_NORMAL, 300);
      boff <= 1'b1;
      busoff_wait(n);
      chk("exit_lo", n >= LO, 1'b1);
      chk("exit_hi", n <= HI, 1'b1);
      boff <= 1'b0;
      wr(OFS_MASTER_CONTROL, 32'h0000_0000);
      boff <= 1'b1;
      busoff_wait(n);
      chk("no_exit", n, 7000);
      wr(OFS_MASTER_CONTROL, 32'h0000_0001);
      wait_mode(ST_INIT, 10);
      wr(OFS_MASTER_CONTROL, 32'h0000_0000);
      busoff_wait(n);
      chk("exit_lo", n >= LO, 1'b1);
      chk("exit_hi", n <= HI, 1'b1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
